// ==== design/smbc_pkg.sv ====
// Purpose: shared constants and types for the static memory burst cycle sequencer
// Assumes: single 40 MHz clock, synchronous active-high reset
// Notes:   widths sized to the external static memory bus
package smbc_pkg;

    localparam int ADDR_W          = 28;
    localparam int DATA_W          = 32;
    localparam int WAIT_W          = 4;
    localparam int BURST_W         = 3;
    localparam logic [BURST_W-1:0] BURST_MIN = 3'h2;
    localparam logic [BURST_W-1:0] BURST_MAX = 3'h4;
    localparam logic [WAIT_W-1:0]  WAIT_RST  = 4'h0;
    localparam logic [BURST_W-1:0] BEAT_RST  = 3'h0;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 28'h0000000;
    localparam logic [DATA_W-1:0]  DATA_RST  = 32'h00000000;
    localparam logic [ADDR_W-1:0]  BEAT_STEP = 28'h0000004;
    localparam int RDATA_DEPTH     = 4;

    typedef enum logic [2:0] {
        SMBC_IDLE  = 3'b000,
        SMBC_SETUP = 3'b001,
        SMBC_WAIT  = 3'b010,
        SMBC_READY = 3'b011,
        SMBC_XFER  = 3'b100,
        SMBC_GAP   = 3'b101
    } smbc_state_t;

    // Request from the processor side
    typedef struct packed {
        logic              write;
        logic              halfword;
        logic              word;
        logic [BURST_W-1:0] beats;
        logic [ADDR_W-1:0] addr;
    } smbc_req_t;

    // Wait-state configuration
    typedef struct packed {
        logic              seq_enable;
        logic [WAIT_W-1:0] wait_nseq;
        logic [WAIT_W-1:0] wait_seq;
    } smbc_cfg_t;

endpackage : smbc_pkg

// ==== design/smbc_rdata_mem.sv ====
// Purpose: small register store holding read beats of one burst
// Assumes: one write port, one read port, registered read data
// Notes:   depth covers the longest burst
`timescale 1ns/100ps
module smbc_rdata_mem
    import smbc_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = RDATA_DEPTH
) (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [WIDTH-1:0]         rd_data
);

    logic [WIDTH-1:0] store [DEPTH];
    logic [WIDTH-1:0] next_rd_data;

    always_comb begin
        next_rd_data = store[rd_idx];
    end

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            store[wr_idx] <= wr_data;
        end
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule : smbc_rdata_mem

// ==== design/smbc_seq.sv ====
// Purpose: sequences single and burst static memory read and write cycles
// Assumes: ready is sampled at the falling edge of the half-rate bus clock
// Notes:   bus clock out is mclk divided by two, driven from a flip-flop
`timescale 1ns/100ps
module smbc_seq
    import smbc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire smbc_req_t         req,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire smbc_cfg_t         cfg,
    input  wire logic              expansion_ready,
    input  wire logic [DATA_W-1:0] mem_rdata,
    output logic                   req_ready,
    output logic                   beat_done,
    output logic [DATA_W-1:0]      rdata,
    output logic                   rdata_valid,
    output logic                   busy,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DATA_W-1:0]      mem_wdata,
    output logic                   mem_wdata_oe,
    output logic                   mem_halfword,
    output logic                   mem_word,
    output logic                   mem_write,
    output logic                   mem_cs_n,
    output logic                   mem_oe_n,
    output logic                   memory_write_strobe_n,
    output logic                   expansion_bus_clock_out
);

    ////////////////////////////////////////////////////////////////////////
    // Bus clock divider and ready sampling point

    logic clk_phase;
    logic next_clk_phase;
    logic ready_fall;

    always_comb begin
        next_clk_phase = ~clk_phase;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_phase               <= 1'b0;
            expansion_bus_clock_out <= 1'b0;
        end else begin
            clk_phase               <= next_clk_phase;
            expansion_bus_clock_out <= next_clk_phase;
        end
    end

    // Output falls on the edge where phase goes high to low
    assign ready_fall = clk_phase;

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer

    smbc_state_t        state;
    smbc_state_t        next_state;
    logic [WAIT_W-1:0]  wait_cnt;
    logic [WAIT_W-1:0]  next_wait_cnt;
    logic [BURST_W-1:0] beats_left;
    logic [BURST_W-1:0] next_beats_left;
    logic [BURST_W-1:0] beat_idx;
    logic [BURST_W-1:0] next_beat_idx;
    logic               sequential;
    logic               next_sequential;
    logic [ADDR_W-1:0]  next_mem_addr;
    logic [DATA_W-1:0]  next_mem_wdata;
    logic               next_mem_wdata_oe;
    logic               next_mem_halfword;
    logic               next_mem_word;
    logic               next_mem_write;
    logic               next_mem_cs_n;
    logic               next_mem_oe_n;
    logic               next_strobe_n;
    logic               next_req_ready;
    logic               next_beat_done;
    logic               next_busy;
    logic [BURST_W-1:0] clamped_beats;
    logic [WAIT_W-1:0]  beat_waits;

    // Burst length clamped to four at most; requests below two give a single beat
    always_comb begin
        if (req.beats > BURST_MAX) begin
            clamped_beats = BURST_MAX;
        end else if (req.beats < BURST_MIN) begin
            clamped_beats = 3'h1;
        end else begin
            clamped_beats = req.beats;
        end
    end

    // Wait count per beat: first beat, and every write when seq_enable is off, take the full count
    always_comb begin
        if (sequential && cfg.seq_enable) begin
            beat_waits = cfg.wait_seq;
        end else if (sequential && !mem_write) begin
            beat_waits = WAIT_RST;
        end else begin
            beat_waits = cfg.wait_nseq;
        end
    end

    always_comb begin
        next_state        = state;
        next_wait_cnt     = wait_cnt;
        next_beats_left   = beats_left;
        next_beat_idx     = beat_idx;
        next_sequential   = sequential;
        next_mem_addr     = mem_addr;
        next_mem_wdata    = mem_wdata;
        next_mem_wdata_oe = mem_wdata_oe;
        next_mem_halfword = mem_halfword;
        next_mem_word     = mem_word;
        next_mem_write    = mem_write;
        next_mem_cs_n     = mem_cs_n;
        next_mem_oe_n     = mem_oe_n;
        next_strobe_n     = 1'b1;
        next_req_ready    = 1'b0;
        next_beat_done    = 1'b0;
        next_busy         = busy;
        case (state)
            SMBC_IDLE: begin
                next_req_ready = 1'b1;
                next_busy      = 1'b0;
                if (req_valid && req_ready) begin
                    next_mem_addr     = req.addr;
                    next_mem_wdata    = req_wdata;
                    next_mem_halfword = req.halfword;
                    next_mem_word     = req.word;
                    next_mem_write    = req.write;
                    next_mem_wdata_oe = req.write;
                    next_beats_left   = clamped_beats;
                    next_beat_idx     = BEAT_RST;
                    next_sequential   = 1'b0;
                    next_mem_cs_n     = 1'b0;
                    next_mem_oe_n     = req.write;
                    next_req_ready    = 1'b0;
                    next_busy         = 1'b1;
                    next_state        = SMBC_SETUP;
                end
            end
            SMBC_SETUP: begin
                // One base wait per access, plus programmed count
                next_wait_cnt = beat_waits;
                next_strobe_n = ~mem_write;
                next_state    = (beat_waits == WAIT_RST) ? SMBC_READY : SMBC_WAIT;
            end
            SMBC_WAIT: begin
                next_strobe_n = ~mem_write;
                next_wait_cnt = wait_cnt - 4'h1;
                if (wait_cnt == 4'h1) begin
                    next_state = SMBC_READY;
                end
            end
            SMBC_READY: begin
                next_strobe_n = ~mem_write;
                // Hold until ready seen high on a falling bus clock edge
                if (ready_fall && expansion_ready) begin
                    next_strobe_n = 1'b1;
                    next_state    = SMBC_XFER;
                end
            end
            SMBC_XFER: begin
                next_beat_done  = 1'b1;
                next_beat_idx   = beat_idx + 3'h1;
                next_beats_left = beats_left - 3'h1;
                next_sequential = 1'b1;
                if (beats_left == 3'h1) begin
                    // Address, size, direction and write data left as is
                    next_mem_cs_n     = 1'b1;
                    next_mem_oe_n     = 1'b1;
                    next_state        = cfg.seq_enable ? SMBC_IDLE : SMBC_GAP;
                    next_req_ready    = cfg.seq_enable;
                end else if (!mem_write) begin
                    // Later read beats skip the setup wait
                    next_mem_addr = mem_addr + BEAT_STEP;
                    next_wait_cnt = cfg.seq_enable ? cfg.wait_seq : WAIT_RST;
                    next_state    = (next_wait_cnt == WAIT_RST) ? SMBC_READY : SMBC_WAIT;
                end else begin
                    next_mem_addr = mem_addr + BEAT_STEP;
                    next_state    = SMBC_SETUP;
                end
            end
            SMBC_GAP: begin
                next_req_ready = 1'b1;
                next_state     = SMBC_IDLE;
            end
            default: begin
                next_state = SMBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state                 <= SMBC_IDLE;
            wait_cnt              <= WAIT_RST;
            beats_left            <= BEAT_RST;
            beat_idx              <= BEAT_RST;
            sequential            <= 1'b0;
            mem_addr              <= ADDR_RST;
            mem_wdata             <= DATA_RST;
            mem_wdata_oe          <= 1'b0;
            mem_halfword          <= 1'b0;
            mem_word              <= 1'b0;
            mem_write             <= 1'b0;
            mem_cs_n              <= 1'b1;
            mem_oe_n              <= 1'b1;
            memory_write_strobe_n <= 1'b1;
            req_ready             <= 1'b0;
            beat_done             <= 1'b0;
            busy                  <= 1'b0;
        end else begin
            state                 <= next_state;
            wait_cnt              <= next_wait_cnt;
            beats_left            <= next_beats_left;
            beat_idx              <= next_beat_idx;
            sequential            <= next_sequential;
            mem_addr              <= next_mem_addr;
            mem_wdata             <= next_mem_wdata;
            mem_wdata_oe          <= next_mem_wdata_oe;
            mem_halfword          <= next_mem_halfword;
            mem_word              <= next_mem_word;
            mem_write             <= next_mem_write;
            mem_cs_n              <= next_mem_cs_n;
            mem_oe_n              <= next_mem_oe_n;
            memory_write_strobe_n <= next_strobe_n;
            req_ready             <= next_req_ready;
            beat_done             <= next_beat_done;
            busy                  <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read beat capture and return

    logic capture;
    logic next_rdata_valid;
    logic [1:0] cap_idx;

    assign capture = (state == SMBC_XFER) && !mem_write;
    assign cap_idx = beat_idx[1:0];

    smbc_rdata_mem #(
        .WIDTH (DATA_W),
        .DEPTH (RDATA_DEPTH)
    ) u_rdata_mem (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (capture),
        .wr_idx  (cap_idx),
        .wr_data (mem_rdata),
        .rd_idx  (cap_idx),
        .rd_data ()
    );

    always_comb begin
        next_rdata_valid = capture;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata       <= DATA_RST;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= next_rdata_valid;
            if (capture) begin
                rdata <= mem_rdata;
            end
        end
    end

endmodule : smbc_seq

// ==== tb/smbc_mem_model.sv ====
// Purpose: far-side static memory with programmable ready stall
// Assumes: stall counted from chip select going low
// Notes:   released data lines show inverted data
`timescale 1ns/100ps
module smbc_mem_model
    import smbc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              cs_n,
    input  wire logic              oe_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [3:0]        stall,
    output logic                   ready,
    output logic [DATA_W-1:0]      rdata
);
    logic [3:0]        cnt = 4'h0;
    logic [DATA_W-1:0] last = 32'h00000000;
    initial ready = 1'b0;
    assign rdata = (!cs_n && !oe_n) ? {addr, 4'ha} : ~last;
    always @(posedge mclk) begin
        if (!cs_n && !oe_n)
            last <= {addr, 4'ha};
        // Deselected: ready toggles every mclk cycle, at the same rate as the clock out
        if (cs_n) begin
            cnt <= 4'h0;
            ready <= ~ready;
        end else begin
            if (cnt != 4'hf)
                cnt <= cnt + 4'h1;
            ready <= (cnt >= stall);
        end
    end
endmodule : smbc_mem_model

// ==== tb/smbc_seq_assertions.sv ====
// Purpose: port-level timing checks of the burst cycle sequencer
// Assumes: config held steady during a burst
// Notes:   helper counters track beats and spacing
`timescale 1ns/100ps
module smbc_seq_assertions
    import smbc_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              req_valid,
    input wire smbc_req_t         req,
    input wire smbc_cfg_t         cfg,
    input wire logic              expansion_ready,
    input wire logic              req_ready,
    input wire logic              beat_done,
    input wire logic              busy,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_wdata,
    input wire logic              mem_halfword,
    input wire logic              mem_word,
    input wire logic              mem_write
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic       tk, fst, seen;
    logic [2:0] nb, exp_nb;
    logic [5:0] st, gp;
    assign tk = req_valid && req_ready;
    always_ff @(posedge mclk) begin
        if (rst) begin
            {nb, exp_nb, st, gp, fst, seen} <= '0;
        end else if (tk) begin
            {nb, st, fst, seen} <= {3'h0, 6'h0, 1'b1, 1'b1};
            exp_nb <= req.beats > BURST_MAX ? BURST_MAX : (req.beats < BURST_MIN ? 3'h1 : req.beats);
        end else begin
            if (beat_done) begin
                {nb, fst, gp} <= {nb + 3'h1, 1'b0, 6'h1};
            end else if (gp != 6'h3f) begin
                gp <= gp + 6'h1;
            end
            if (st != 6'h3f)
                st <= st + 6'h1;
        end
    end
    property p_stall; !expansion_ready [*4] |=> !beat_done; endproperty
    a_stall: assert property (p_stall) else $error("beat while ready low");
    property p_max; nb <= BURST_MAX; endproperty
    a_max: assert property (p_max) else $error("more than four beats");
    property p_cnt; tk && seen |-> nb == exp_nb; endproperty
    a_cnt: assert property (p_cnt) else $error("wrong beat count");
    property p_hold; !busy && !$past(busy) && !tk && !$past(tk) |=> $stable(mem_addr) && $stable(mem_write)
        && $stable(mem_word) && $stable(mem_halfword); endproperty
    a_hold: assert property (p_hold) else $error("cycle outputs moved while idle");
    property p_wdat; !busy && !$past(busy) && !tk && !$past(tk) && mem_write |=> $stable(mem_wdata); endproperty
    a_wdat: assert property (p_wdat) else $error("write data moved while idle");
    property p_first; beat_done && fst |-> st >= {2'h0, cfg.wait_nseq} + 6'h2; endproperty
    a_first: assert property (p_first) else $error("first beat too early");
    property p_wgap; beat_done && !fst && mem_write |-> gp > {2'h0, cfg.wait_nseq} + 6'h1; endproperty
    a_wgap: assert property (p_wgap) else $error("write beat without wait");
    property p_sgap; beat_done && !fst && !mem_write && cfg.seq_enable |-> gp > {2'h0, cfg.wait_seq}; endproperty
    a_sgap: assert property (p_sgap) else $error("sequential read wait short");
    property p_idle; $fell(busy) && cfg.seq_enable |-> ##[0:2] req_ready; endproperty
    a_idle: assert property (p_idle) else $error("idle gap with sequential access");
endmodule : smbc_seq_assertions
bind smbc_seq smbc_seq_assertions i_chk (.mclk, .rst, .req_valid, .req, .cfg, .expansion_ready, .req_ready,
    .beat_done, .busy, .mem_addr, .mem_wdata, .mem_halfword, .mem_word, .mem_write);

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the burst cycle sequencer
// Assumes: 40 MHz clock, reset held 20 cycles
// Notes:   latencies compared between table rows
`timescale 1ns/100ps
module tb_top;
    import smbc_pkg::*;
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t bad %0h", $time, a); end end
    typedef struct packed {
        logic w; logic [2:0] b; logic [3:0] wn; logic sq; logic [3:0] ws; logic [3:0] st; logic [2:0] nb;
    } smbc_row_t;
    logic mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, expansion_ready;
    logic req_ready, beat_done, rdata_valid, busy, mem_cs_n, mem_oe_n, mem_halfword, mem_word, mem_write;
    smbc_req_t         req = '0;
    smbc_cfg_t         cfg = '0;
    logic [DATA_W-1:0] req_wdata = '0, mem_rdata, rdata, mem_wdata;
    logic [ADDR_W-1:0] mem_addr;
    logic [3:0]        stall = 4'h0;
    int mismatches = 0, samples_checked = 0, lat[8], gap[8];
    smbc_row_t rows [8] = '{
        '{1'b0, 3'h4, 4'h0, 1'b0, 4'h0, 4'h0, 3'h4},
        '{1'b1, 3'h4, 4'h0, 1'b0, 4'h0, 4'h0, 3'h4},
        '{1'b0, 3'h2, 4'h3, 1'b0, 4'h0, 4'h0, 3'h2},
        '{1'b0, 3'h2, 4'h3, 1'b0, 4'h0, 4'h2, 3'h2},
        '{1'b0, 3'h2, 4'h3, 1'b0, 4'h0, 4'h9, 3'h2},
        '{1'b0, 3'h3, 4'h1, 1'b1, 4'h4, 4'h0, 3'h3},
        '{1'b0, 3'h7, 4'h1, 1'b1, 4'h0, 4'h0, 3'h4},
        '{1'b1, 3'h1, 4'h2, 1'b1, 4'h0, 4'h0, 3'h1}};
    always #12.5 mclk = ~mclk;
    smbc_seq i_smbc_seq (.mclk, .rst, .req_valid, .req, .req_wdata, .cfg, .expansion_ready, .mem_rdata,
        .req_ready, .beat_done, .rdata, .rdata_valid, .busy, .mem_addr, .mem_wdata, .mem_wdata_oe(),
        .mem_halfword, .mem_word, .mem_write, .mem_cs_n, .mem_oe_n, .memory_write_strobe_n(),
        .expansion_bus_clock_out());
    smbc_mem_model i_smbc_mem_model (.mclk, .cs_n(mem_cs_n), .oe_n(mem_oe_n), .addr(mem_addr), .stall,
        .ready(expansion_ready), .rdata(mem_rdata));
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic run(input smbc_row_t r, input int k);
        logic [ADDR_W-1:0] a;
        int n, m, last;
        a = {20'h00010, k[3:0], 4'h0};
        {n, m, last} = '0;
        cfg <= '{r.sq, r.wn, r.ws};
        stall <= r.st;
        req <= '{r.w, 1'b0, 1'b1, r.b, a};
        req_wdata <= {a, 4'h5};
        req_valid <= 1'b1;
        do @(posedge mclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        for (int t = 1; t <= 60; t++) begin
            @(posedge mclk);
            if (rdata_valid === 1'b1) begin
                `CHK(rdata, {a + ADDR_W'(4 * m), 4'ha})
                m++;
            end
            if (beat_done === 1'b1) begin
                if (n == 0) lat[k] = t;
                if (n == 1) gap[k] = t - last;
                last = t;
                n++;
            end
        end
        `CHK(3'(n), r.nb)
        `CHK(mem_addr, a + ADDR_W'(4 * (r.nb - 3'h1)))
        `CHK({mem_write, mem_word, mem_halfword}, {r.w, 2'b10})
        if (r.w) `CHK(mem_wdata, {a, 4'h5})
    endtask : run
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(req_ready, 1'b1)
        for (int i = 0; i < 8; i++) run(rows[i], i);
        `CHK(lat[3] <= lat[2] + 1, 1'b1)
        `CHK(lat[4] >= lat[2] + 4, 1'b1)
        `CHK(gap[0] < gap[1], 1'b1)
        `CHK(gap[5] > 4, 1'b1)
        // Reset in the middle of a single-beat write must abort cleanly
        req_valid <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b1;
        req_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK({busy, mem_cs_n}, 2'b01)
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(req_ready, 1'b1)
        summarize();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        summarize();
    end
endmodule : tb_top
